/* design/isp_engine.v */
`timescale 1ns/100ps
`include "isp_consts.vh"
module isp_engine (
  input  wire        CLK_SYS_I,
  input  wire        RSTN_I,
  input  wire        BOOT_FORCE_PIN_I,     // reads one at high voltage
  output wire        LOAD_CLOCK_PIN_O,     // load clock out
  output wire        LOAD_CLOCK_PIN_OEN_O, // low while driving
  input  wire        SERIAL_SHIFT_CLOCK_I, // host shift clock
  input  wire        SERIAL_DATA_I,        // host to device data
  output wire        SERIAL_DATA_O,        // device to host data
  input  wire        FLASH_EXEC_SELECT_I,  // option bit for flash run
  input  wire        SECURITY_I,           // flash security set
  input  wire [7:0]  OPTION_REG_I,         // option register value
  input  wire        KEY_WR_I,             // cpu write to key register
  input  wire [7:0]  KEY_DATA_I,           // written key byte
  input  wire        JUMP_TO_BOOT_I,       // cpu executes keyed jump
  input  wire [7:0]  JUMP_ENTRY_I,         // entry point argument
  input  wire [7:0]  USER_ACC_I,           // accumulator, confirm key
  input  wire [15:0] USER_ADDR_I,          // user address registers
  input  wire [7:0]  USER_WDATA_I,         // user write data register
  input  wire [7:0]  USER_COUNT_I,         // user byte count
  output reg         BOOT_EXEC_O,          // fetching from boot rom
  output reg  [15:0] FETCH_ADDR_O,         // start fetch address
  output reg         CORE_RESET_O,         // self reset pulse
  output reg         ISP_ENABLED_O,        // commands accepted
  output reg         KEY_ARMED_O,          // jump permission live
  output reg  [7:0]  TIMING_O,             // write pulse timing
  output reg         FL_REQ_O,             // flash operation strobe
  output reg  [2:0]  FL_OP_O,              // flash operation code
  output reg  [15:0] FL_ADDR_O,            // flash address
  output reg  [7:0]  FL_WDATA_O,           // flash write data
  input  wire        FL_DONE_I,            // flash operation finished
  input  wire [7:0]  FL_RDATA_I,           // flash read data
  output reg         USER_DONE_O           // user service finished
);
  // flash operation codes
  localparam OP_READ  = 3'h0;
  localparam OP_WRITE = 3'h1;
  localparam OP_PAGE  = 3'h2;
  localparam OP_MASS  = 3'h3;
  // command states
  localparam S_CMD   = 4'h0;
  localparam S_PARAM = 4'h1;
  localparam S_FLASH = 4'h2;
  localparam S_SEND  = 4'h3;
  localparam S_WAIT  = 4'h4;
  localparam S_USER  = 4'h5;
  localparam DEB_W   = 8;
  localparam [DEB_W-1:0] DEB_CYC = `DEBOUNCE_CYC;

  // two-flop synchronisers on every pin input
  reg [1:0] bf_s_q, sck_s_q, sdi_s_q;
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bf_s_q  <= 2'b00;
      sck_s_q <= 2'b00;
      sdi_s_q <= 2'b00;
    end else begin
      bf_s_q  <= {bf_s_q[0], BOOT_FORCE_PIN_I};
      sck_s_q <= {sck_s_q[0], SERIAL_SHIFT_CLOCK_I};
      sdi_s_q <= {sdi_s_q[0], SERIAL_DATA_I};
    end
  end
  wire boot_pin = bf_s_q[1];

  // load clock driven while boot forced
  reg lclk_q;  // divided load clock
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) lclk_q <= 1'b0;
    else         lclk_q <= ~lclk_q;
  end
  assign LOAD_CLOCK_PIN_O     = lclk_q;
  assign LOAD_CLOCK_PIN_OEN_O = ~boot_pin;

  // byte shifter, whole bytes on slave link
  wire       rx_vld;
  wire [7:0] rx_byte;
  reg        tx_load_q;
  reg  [7:0] tx_byte_q;
  isp_shifter u_shift (
    .clk      (CLK_SYS_I),
    .rstn     (RSTN_I),
    .sck_i    (sck_s_q[1]),
    .sdi_i    (sdi_s_q[1]),
    .load_i   (tx_load_q),
    .tx_i     (tx_byte_q),
    .sdo_o    (SERIAL_DATA_O),
    .rx_vld_o (rx_vld),
    .rx_o     (rx_byte)
  );

  // masked read value, used by the serial path only
  function [7:0] mask_rd;
    input [15:0] a;
    input [7:0]  d;
    input        sec;
    begin
      if (a == `OPTION_ALIAS) mask_rd = OPTION_REG_I;
      else if (sec)           mask_rd = `SECURE_FILL;
      else                    mask_rd = d;
    end
  endfunction

  reg [3:0]  st_q;      // state
  reg [7:0]  cmd_q;     // current command
  reg [2:0]  pidx_q;    // parameter index
  reg [15:0] cnt_q;     // block count
  reg        armed_q;   // forced entry seen at reset
  reg [1:0]  hold_q;    // cycles since release
  reg [DEB_W-1:0] deb_q; // debounce counter
  reg [3:0]  key_q;     // key life counter
  reg        user_q;    // current op from user mode
  reg [7:0]  uent_q;    // user entry point

  // number of parameter bytes before action
  function [2:0] n_param;
    input [7:0] c;
    begin
      case (c)
        `CMD_SET_TIMING:  n_param = 3'h1;
        `CMD_PAGE_ERASE:  n_param = 3'h2;
        `CMD_MASS_ERASE:  n_param = 3'h1;
        `CMD_READ_BYTE:   n_param = 3'h2;
        `CMD_MULTI_READ:  n_param = 3'h4;
        `CMD_WRITE_BYTE:  n_param = 3'h3;
        `CMD_MULTI_WRITE: n_param = 3'h3;
        default:          n_param = 3'h0;
      endcase
    end
  endfunction

  // entry control, key register, command engine
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      BOOT_EXEC_O   <= 1'b0;
      FETCH_ADDR_O  <= 16'h0000;
      CORE_RESET_O  <= 1'b0;
      ISP_ENABLED_O <= 1'b0;
      KEY_ARMED_O   <= 1'b0;
      TIMING_O      <= `TIMING_RESET;
      FL_REQ_O      <= 1'b0;
      FL_OP_O       <= OP_READ;
      FL_ADDR_O     <= 16'h0000;
      FL_WDATA_O    <= 8'h00;
      USER_DONE_O   <= 1'b0;
      st_q      <= S_CMD;
      cmd_q     <= 8'h00;
      pidx_q    <= 3'h0;
      cnt_q     <= 16'h0000;
      armed_q   <= 1'b0;
      hold_q    <= 2'h0;
      deb_q     <= {DEB_W{1'b0}};
      key_q     <= 4'h0;
      user_q    <= 1'b0;
      uent_q    <= 8'h00;
      tx_load_q <= 1'b0;
      tx_byte_q <= 8'hff;
    end else begin
      FL_REQ_O     <= 1'b0;
      CORE_RESET_O <= 1'b0;
      USER_DONE_O  <= 1'b0;
      tx_load_q    <= 1'b0;
      // high level must outlast release; boot from zero
      if (hold_q != `FORCE_HOLD) begin
        hold_q <= hold_q + 2'h1;
        if (boot_pin && hold_q == (`FORCE_HOLD - 2'h1)) begin
          armed_q      <= 1'b1;
          BOOT_EXEC_O  <= 1'b1;
          FETCH_ADDR_O <= 16'h0000;
        end
      end
      // wait for low, debounce, then enable
      if (armed_q && !ISP_ENABLED_O) begin
        if (boot_pin) deb_q <= {DEB_W{1'b0}};
        else if (deb_q == DEB_CYC) ISP_ENABLED_O <= 1'b1;
        else deb_q <= deb_q + {{(DEB_W-1){1'b0}}, 1'b1};
      end
      // key arms jump for eight cycles
      if (KEY_WR_I && KEY_DATA_I[7:2] == `KEY_PATTERN) begin
        key_q       <= `KEY_LIFE;
        KEY_ARMED_O <= 1'b1;
      end else if (key_q != 4'h0) begin
        key_q       <= key_q - 4'h1;
        KEY_ARMED_O <= (key_q != 4'h1);
      end
      case (st_q)
        S_CMD: begin
          // keyed jump starts a user service
          if (JUMP_TO_BOOT_I && KEY_ARMED_O) begin
            uent_q    <= JUMP_ENTRY_I;
            user_q    <= 1'b1;
            FL_ADDR_O <= USER_ADDR_I;
            st_q      <= S_USER;
          end else if (ISP_ENABLED_O && rx_vld) begin
            if (n_param(rx_byte) != 3'h0) begin
              cmd_q  <= rx_byte;
              pidx_q <= 3'h0;
              user_q <= 1'b0;
              st_q   <= S_PARAM;
            end else if (rx_byte == `CMD_EXIT) begin
              // self reset, flash run if selected
              CORE_RESET_O  <= 1'b1;
              BOOT_EXEC_O   <= ~FLASH_EXEC_SELECT_I;
              FETCH_ADDR_O  <= 16'h0000;
              ISP_ENABLED_O <= ~FLASH_EXEC_SELECT_I;
              // drop the entry, else the settled debounce re-enables
              armed_q       <= ~FLASH_EXEC_SELECT_I;
            end
          end
        end
        S_PARAM: if (rx_vld) begin
          pidx_q <= pidx_q + 3'h1;
          case (pidx_q)
            3'h0: FL_ADDR_O[15:8] <= rx_byte;
            3'h1: FL_ADDR_O[7:0]  <= rx_byte;
            3'h2: cnt_q[15:8]     <= rx_byte;
            default: cnt_q[7:0]   <= rx_byte;
          endcase
          if (pidx_q == 3'h2 && cmd_q == `CMD_MULTI_WRITE)
            cnt_q <= {8'h00, rx_byte};
          if (pidx_q == 3'h2 && cmd_q == `CMD_WRITE_BYTE)
            FL_WDATA_O <= rx_byte;
          if (pidx_q == n_param(cmd_q) - 3'h1) begin
            st_q <= S_CMD;
            case (cmd_q)
              `CMD_SET_TIMING: TIMING_O <= rx_byte;
              `CMD_MASS_ERASE: begin
                FL_OP_O  <= OP_MASS;
                FL_REQ_O <= 1'b1;
                st_q     <= S_FLASH;
              end
              `CMD_PAGE_ERASE: begin
                FL_OP_O  <= OP_PAGE;
                FL_REQ_O <= 1'b1;
                st_q     <= S_FLASH;
              end
              `CMD_WRITE_BYTE: begin
                FL_OP_O    <= OP_WRITE;
                FL_WDATA_O <= rx_byte;
                FL_REQ_O   <= 1'b1;
                st_q       <= S_FLASH;
              end
              `CMD_MULTI_WRITE: begin
                cnt_q <= {8'h00, rx_byte};
                if (rx_byte != 8'h00 && rx_byte <= `MULTI_WRITE_MAX)
                  st_q <= S_WAIT;
              end
              default: begin
                if (cmd_q == `CMD_READ_BYTE) cnt_q <= 16'h0001;
                else cnt_q <= {cnt_q[15:8], rx_byte} & `MULTI_READ_MAX;
                FL_OP_O <= OP_READ;
                if (cmd_q == `CMD_READ_BYTE ||
                    ({cnt_q[15:8], rx_byte} & `MULTI_READ_MAX) != 16'h0)
                begin
                  FL_REQ_O <= 1'b1;
                  st_q     <= S_FLASH;
                end
              end
            endcase
          end
        end
        S_WAIT: if (rx_vld) begin
          // block write byte arrives
          FL_WDATA_O <= rx_byte;
          FL_OP_O    <= OP_WRITE;
          FL_REQ_O   <= 1'b1;
          st_q       <= S_FLASH;
        end
        S_FLASH: if (FL_DONE_I) begin
          st_q <= S_CMD;
          if (FL_OP_O == OP_READ && !user_q) begin
            tx_byte_q <= mask_rd(FL_ADDR_O, FL_RDATA_I, SECURITY_I);
            tx_load_q <= 1'b1;
            st_q      <= S_SEND;
          end else if (cmd_q == `CMD_MULTI_WRITE && !user_q) begin
            FL_ADDR_O <= FL_ADDR_O + 16'h0001;
            cnt_q     <= cnt_q - 16'h0001;
            if (cnt_q != 16'h0001) st_q <= S_WAIT;
          end else if (user_q) begin
            USER_DONE_O <= (cnt_q <= 16'h0001);
            FL_ADDR_O   <= FL_ADDR_O + 16'h0001;
            cnt_q       <= cnt_q - 16'h0001;
            if (cnt_q > 16'h0001) begin
              FL_REQ_O <= 1'b1;
              st_q     <= S_FLASH;
            end
            user_q <= (cnt_q > 16'h0001);
            // user mass erase lands in serial mode
            if (FL_OP_O == OP_MASS) begin
              BOOT_EXEC_O   <= 1'b1;
              ISP_ENABLED_O <= 1'b1;
              armed_q       <= 1'b1;
            end
          end
        end
        S_SEND: if (rx_vld) begin
          // next byte once host clocks one out
          FL_ADDR_O <= FL_ADDR_O + 16'h0001;
          cnt_q     <= cnt_q - 16'h0001;
          if (cnt_q != 16'h0001) begin
            FL_REQ_O <= 1'b1;
            st_q     <= S_FLASH;
          end else st_q <= S_CMD;
        end
        S_USER: begin
          st_q     <= S_FLASH;
          FL_REQ_O <= 1'b1;
          cnt_q    <= 16'h0001;
          case (uent_q)
            `ENT_PAGE_ERASE: FL_OP_O <= OP_PAGE;
            `ENT_MASS_ERASE: begin
              FL_OP_O  <= OP_MASS;
              FL_REQ_O <= (USER_ACC_I == `MASS_CONFIRM);
              if (USER_ACC_I != `MASS_CONFIRM) st_q <= S_CMD;
            end
            `ENT_READ_BYTE:  FL_OP_O <= OP_READ;
            `ENT_WRITE_BYTE: begin
              FL_OP_O    <= OP_WRITE;
              FL_WDATA_O <= USER_WDATA_I;
            end
            `ENT_MULTI_READ: begin
              FL_OP_O <= OP_READ;
              cnt_q   <= {8'h00, USER_COUNT_I};
            end
            `ENT_MULTI_WRITE: begin
              FL_OP_O    <= OP_WRITE;
              FL_WDATA_O <= USER_WDATA_I;
              cnt_q      <= {8'h00, USER_COUNT_I};
            end
            default: begin
              FL_REQ_O <= 1'b0;
              st_q     <= S_CMD;
            end
          endcase
        end
        default: st_q <= S_CMD;
      endcase
    end
  end
endmodule

/* design/isp_consts.vh */
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH
// command codes on the serial link
`define CMD_SET_TIMING   8'h3b
`define CMD_PAGE_ERASE   8'hb3
`define CMD_MASS_ERASE   8'hbf
`define CMD_READ_BYTE    8'h1d
`define CMD_MULTI_READ   8'ha3
`define CMD_WRITE_BYTE   8'h71
`define CMD_MULTI_WRITE  8'h8f
`define CMD_EXIT         8'hd3
// user-mode entry points given to the jump_to_boot argument
`define ENT_PAGE_ERASE   8'h17
`define ENT_MASS_ERASE   8'h1a
`define ENT_READ_BYTE    8'h11
`define ENT_MULTI_READ   8'h26
`define ENT_WRITE_BYTE   8'h14
`define ENT_MULTI_WRITE  8'h23
// mass erase confirmation in user mode
`define MASS_CONFIRM     8'h55
// key pattern in bits 7..2 and its life
`define KEY_PATTERN      6'h26
`define KEY_LIFE         4'h8
// masked read value and option register alias
`define SECURE_FILL      8'hff
`define OPTION_ALIAS     16'hffff
// timing register value for a 10 mhz input clock
`define TIMING_RESET     8'h7b
// extra cycles the boot-force level must outlast reset
`define FORCE_HOLD       2'h3
// debounce of boot_force_pin low: 1000 ns at the 8 ns clock, rounded up
`define DEBOUNCE_CYC     8'h7d
// block count limits
`define MULTI_WRITE_MAX  8'h10
`define MULTI_READ_MAX   16'h7fff
`endif

/* design/isp_shifter.v */
`timescale 1ns/100ps
`include "isp_consts.vh"
// byte shifter, slave on sampled shift clock, msb first
module isp_shifter (
  input  wire       clk,
  input  wire       rstn,
  input  wire       sck_i,     // synchronised shift clock
  input  wire       sdi_i,     // synchronised serial data in
  input  wire       load_i,    // load tx byte
  input  wire [7:0] tx_i,      // byte to send
  output reg        sdo_o,     // serial data out
  output reg        rx_vld_o,  // one-cycle byte strobe
  output reg  [7:0] rx_o       // received byte
);
  reg       sck_q;    // previous shift clock
  reg [2:0] cnt_q;    // bit count
  reg [7:0] sh_q;     // receive shift
  reg [7:0] tx_q;     // transmit shift
  wire rise = sck_i & ~sck_q;
  wire fall = ~sck_i & sck_q;
  // sample on rising, shift out on falling
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q    <= 1'b0;
      cnt_q    <= 3'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'hff;
      sdo_o    <= 1'b1;
      rx_vld_o <= 1'b0;
      rx_o     <= 8'h00;
    end else begin
      sck_q    <= sck_i;
      rx_vld_o <= 1'b0;
      if (load_i) begin
        tx_q  <= tx_i;
        sdo_o <= tx_i[7];
      end else if (fall) begin
        // idle line sends ones
        tx_q  <= {tx_q[6:0], 1'b1};
        sdo_o <= tx_q[6];
      end
      if (rise) begin
        sh_q  <= {sh_q[6:0], sdi_i};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          rx_o     <= {sh_q[6:0], sdi_i};
          rx_vld_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* testbench/isp_engine_asserts.sv */
`timescale 1ns/100ps
// pin-level checks on entry, load clock, key and exit behaviour
module isp_engine_asserts (
  input wire        CLK_SYS_I,
  input wire        RSTN_I,
  input wire        BOOT_FORCE_PIN_I,
  input wire        LOAD_CLOCK_PIN_O,
  input wire        LOAD_CLOCK_PIN_OEN_O,
  input wire        FLASH_EXEC_SELECT_I,
  input wire        KEY_WR_I,
  input wire [7:0]  KEY_DATA_I,
  input wire        JUMP_TO_BOOT_I,
  input wire        BOOT_EXEC_O,
  input wire [15:0] FETCH_ADDR_O,
  input wire        CORE_RESET_O,
  input wire        ISP_ENABLED_O,
  input wire        KEY_ARMED_O,
  input wire [7:0]  TIMING_O,
  input wire        USER_DONE_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);

  reg  [7:0] low_cnt_q;  // cycles the boot pin has read low
  wire [7:0] low_cnt_d;
  wire       key_hit;    // key write with the arming pattern
  assign key_hit = KEY_WR_I && (KEY_DATA_I[7:2] == 6'h26);
  // saturate so a long idle pin never wraps back under the limit
  assign low_cnt_d = BOOT_FORCE_PIN_I ? 8'h00 :
                     (low_cnt_q == 8'hff) ? low_cnt_q : low_cnt_q + 8'h01;

  // low-level run length of the boot pin
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      low_cnt_q <= 8'h00;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  sequence forced_release_s;
    $rose(RSTN_I) ##0 BOOT_FORCE_PIN_I [*4];
  endsequence

  timing_reset_a:
    assert property ($rose(RSTN_I) |-> TIMING_O == 8'h7b)
    else $error("timing value wrong after reset");
  boot_entry_a:
    assert property (forced_release_s |-> ##[0:3]
      (BOOT_EXEC_O && FETCH_ADDR_O == 16'h0000))
    else $error("forced entry did not start at boot zero");
  oen_force_a:
    assert property (BOOT_FORCE_PIN_I [*3] |-> !LOAD_CLOCK_PIN_OEN_O)
    else $error("load clock not driven while forced");
  oen_release_a:
    assert property (!BOOT_FORCE_PIN_I [*3] |-> LOAD_CLOCK_PIN_OEN_O)
    else $error("load clock driven without force");
  load_toggle_a:
    assert property (!LOAD_CLOCK_PIN_OEN_O [*3] |->
      LOAD_CLOCK_PIN_O != $past(LOAD_CLOCK_PIN_O))
    else $error("load clock stalled while driven");
  isp_debounce_a:
    assert property ($rose(ISP_ENABLED_O) |-> low_cnt_q >= 8'h7d)
    else $error("commands enabled before pin debounced");
  key_arm_a:
    assert property (key_hit |=> KEY_ARMED_O)
    else $error("matching key did not arm");
  key_life_a:
    assert property (key_hit ##1 (!KEY_WR_I && !JUMP_TO_BOOT_I) [*8]
      |=> !KEY_ARMED_O)
    else $error("key stayed armed past its life");
  key_miss_a:
    assert property (KEY_WR_I && KEY_DATA_I[7:2] != 6'h26 && !KEY_ARMED_O
      |=> !KEY_ARMED_O)
    else $error("wrong key armed the jump");
  jump_locked_a:
    assert property (JUMP_TO_BOOT_I && !KEY_ARMED_O |=> !USER_DONE_O [*8])
    else $error("service ran without armed key");
  exit_flash_a:
    assert property (CORE_RESET_O && FLASH_EXEC_SELECT_I |-> ##[0:2]
      !BOOT_EXEC_O)
    else $error("exit did not return to flash");

  cover property (forced_release_s);
  cover property (key_hit ##1 JUMP_TO_BOOT_I);
  cover property ($rose(ISP_ENABLED_O));
endmodule

bind isp_engine isp_engine_asserts chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
  .BOOT_FORCE_PIN_I(BOOT_FORCE_PIN_I), .LOAD_CLOCK_PIN_O(LOAD_CLOCK_PIN_O),
  .LOAD_CLOCK_PIN_OEN_O(LOAD_CLOCK_PIN_OEN_O),
  .FLASH_EXEC_SELECT_I(FLASH_EXEC_SELECT_I), .KEY_WR_I(KEY_WR_I),
  .KEY_DATA_I(KEY_DATA_I), .JUMP_TO_BOOT_I(JUMP_TO_BOOT_I),
  .BOOT_EXEC_O(BOOT_EXEC_O), .FETCH_ADDR_O(FETCH_ADDR_O),
  .CORE_RESET_O(CORE_RESET_O), .ISP_ENABLED_O(ISP_ENABLED_O),
  .KEY_ARMED_O(KEY_ARMED_O), .TIMING_O(TIMING_O), .USER_DONE_O(USER_DONE_O)
);

/* testbench/isp_host.sv */
`timescale 1ns/100ps
// host programmer, master of the 80 ns shift clock, msb first
module isp_host (
  output reg  sck_o,  // shift clock, low between frames
  output reg  sdo_o,  // host to device data
  input  wire sdi_i   // device to host data
);
  initial begin
    sck_o = 1'b0;
    sdo_o = 1'b1;
  end

  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      // gap leaves the device time for flash work between bytes
      #203;
      for (i = 7; i >= 0; i = i - 1) begin
        sdo_o = tx[i];
        #40 sck_o = 1'b1;
        rx[i] = sdi_i;
        #40 sck_o = 1'b0;
      end
      // released line flips so a stale bit never looks valid
      sdo_o = ~sdo_o;
    end
  endtask
endmodule

/* testbench/isp_engine_tb.sv */
`timescale 1ns/100ps
`include "isp_consts.vh"
module isp_engine_tb;
  localparam [7:0] OPT = 8'h5c;  // option register content
  reg         clk = 1'b0, rstn = 1'b0, boot = 1'b1, flash_exec_select = 1'b0;
  reg         sec = 1'b0, key_wr = 1'b0, jmp = 1'b0, fl_done = 1'b0;
  reg  [7:0]  key_d = 8'h00, ent = 8'h00, acc = 8'h00, uwd = 8'h00;
  reg  [7:0]  ucnt = 8'h00, fl_rd = 8'h00, l_wd, rx;
  reg  [15:0] uadr = 16'h0000, l_adr;
  reg  [15:0] n_req = 16'h0000, n_rst = 16'h0000, n_done = 16'h0000;
  reg  [2:0]  l_op;
  integer     failures = 0, n_tests = 0, cyc = 0;
  wire        sck, sdi, sdo, lck, lck_oen, bexec, crst, isp_en, armed;
  wire        flreq, udone;
  wire [15:0] faddr, fladdr;
  wire [7:0]  tim, flwd;
  wire [2:0]  flop;

  always #4 clk = ~clk;

  isp_engine dut_u (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .BOOT_FORCE_PIN_I(boot),
    .LOAD_CLOCK_PIN_O(lck), .LOAD_CLOCK_PIN_OEN_O(lck_oen),
    .SERIAL_SHIFT_CLOCK_I(sck), .SERIAL_DATA_I(sdi), .SERIAL_DATA_O(sdo),
    .FLASH_EXEC_SELECT_I(flash_exec_select), .SECURITY_I(sec), .OPTION_REG_I(OPT),
    .KEY_WR_I(key_wr), .KEY_DATA_I(key_d), .JUMP_TO_BOOT_I(jmp),
    .JUMP_ENTRY_I(ent), .USER_ACC_I(acc), .USER_ADDR_I(uadr),
    .USER_WDATA_I(uwd), .USER_COUNT_I(ucnt), .BOOT_EXEC_O(bexec),
    .FETCH_ADDR_O(faddr), .CORE_RESET_O(crst), .ISP_ENABLED_O(isp_en),
    .KEY_ARMED_O(armed), .TIMING_O(tim), .FL_REQ_O(flreq), .FL_OP_O(flop),
    .FL_ADDR_O(fladdr), .FL_WDATA_O(flwd), .FL_DONE_I(fl_done),
    .FL_RDATA_I(fl_rd), .USER_DONE_O(udone)
  );
  isp_host host_u (.sck_o(sck), .sdo_o(sdi), .sdi_i(sdo));

  function [7:0] fdat(input [15:0] a);
    fdat = a[7:0] ^ 8'ha5;
  endfunction

  // hang limit: a stalled run counts as a mismatch
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 30000) begin
      failures = failures + 1;
      test_done;
    end
  end

  // flash stub and pulse counters
  always @(posedge clk) begin
    if (crst === 1'b1) n_rst = n_rst + 16'h1;
    if (udone === 1'b1) n_done = n_done + 16'h1;
    if (flreq === 1'b1) begin
      n_req = n_req + 16'h1;
      l_op = flop;
      l_adr = fladdr;
      l_wd = flwd;
      fork
        begin
          repeat (3) @(posedge clk);
          #1 fl_done = 1'b1;
          fl_rd = fdat(l_adr);
          @(posedge clk);
          #1 fl_done = 1'b0;
          fl_rd = ~fl_rd;  // data not held past the strobe
        end
      join_none
    end
  end

  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tx(input [7:0] b);
    host_u.xfer(b, rx);
  endtask
  task cmd3(input [7:0] c, input [15:0] a);
    begin
      tx(c);
      tx(a[15:8]);
      tx(a[7:0]);
    end
  endtask
  // bounded wait for a count of flash requests, then settle
  task wait_n(input [15:0] n);
    integer k;
    begin
      for (k = 0; k < 400 && n_req !== n; k = k + 1)
        @(posedge clk);
      repeat (10) @(posedge clk);
      #1;
    end
  endtask
  task rd(input [15:0] a, input [7:0] exp);
    begin
      cmd3(`CMD_READ_BYTE, a);
      tx(8'h00);
      chk(rx, exp);
    end
  endtask
  // key write, then the boot jump while the key lives
  task svc(input [7:0] k, input [7:0] e);
    begin
      @(posedge clk);
      #1 key_wr = 1'b1;
      key_d = k;
      @(posedge clk);
      #1 key_wr = 1'b0;
      chk(armed, k[7:2] == `KEY_PATTERN);
      jmp = 1'b1;
      ent = e;
      @(posedge clk);
      #1 jmp = 1'b0;
    end
  endtask

  task t_entry;
    begin
      // boot force high while reset is held
      repeat (8) @(posedge clk);
      #1 chk(tim, `TIMING_RESET);
      rstn = 1'b1;
      // pin held well past the end of reset
      repeat (8) @(posedge clk);
      #1 chk(bexec, 1'b1);
      chk(faddr, 16'h0000);
      chk(lck_oen, 1'b0);
      chk(isp_en, 1'b0);
      tx(`CMD_SET_TIMING);
      @(posedge clk) #1 boot = 1'b0;
      repeat (60) @(posedge clk);
      #1 chk(isp_en, 1'b0);
      repeat (200) @(posedge clk);
      #1 chk(isp_en, 1'b1);
      chk(lck_oen, 1'b1);
      chk(tim, `TIMING_RESET);
    end
  endtask

  task t_cmds;
    reg [15:0] n0;
    begin
      tx(`CMD_SET_TIMING);
      tx(8'h42);
      wait_n(n_req);
      chk(tim, 8'h42);
      n0 = n_req;
      tx(8'h00);
      tx(8'hc4);
      wait_n(n0);
      chk(n_req, n0);
      chk(tim, 8'h42);
      cmd3(`CMD_PAGE_ERASE, 16'h1240);
      wait_n(n0 + 16'h1);
      chk(l_op, 3'h2);
      chk(l_adr, 16'h1240);
      tx(`CMD_MASS_ERASE);
      tx(`MASS_CONFIRM);
      wait_n(n0 + 16'h2);
      chk(l_op, 3'h3);
      rd(16'h0321, fdat(16'h0321));
      cmd3(`CMD_MULTI_READ, 16'h0410);
      tx(8'h00);
      tx(8'h02);
      tx(8'h00);
      chk(rx, fdat(16'h0410));
      tx(8'h00);
      chk(rx, fdat(16'h0411));
      @(posedge clk) #1 sec = 1'b1;
      rd(16'h0321, `SECURE_FILL);
      rd(`OPTION_ALIAS, OPT);
      @(posedge clk) #1 sec = 1'b0;
      n0 = n_req;
      cmd3(`CMD_WRITE_BYTE, 16'h2001);
      tx(8'h9c);
      wait_n(n0 + 16'h1);
      chk(l_op, 3'h1);
      chk(l_adr, 16'h2001);
      chk(l_wd, 8'h9c);
      // block kept inside one 64-byte page
      cmd3(`CMD_MULTI_WRITE, 16'h2008);
      tx(8'h02);
      tx(8'h11);
      tx(8'h22);
      wait_n(n0 + 16'h3);
      chk(n_req, n0 + 16'h3);
      chk(l_adr, 16'h2009);
      chk(l_wd, 8'h22);
      // exit without the flash option stays in the boot rom
      n0 = n_rst;
      tx(`CMD_EXIT);
      wait_n(n_req);
      chk(n_rst, n0 + 16'h1);
      chk(bexec, 1'b1);
      chk(isp_en, 1'b1);
      flash_exec_select = 1'b1;
      tx(`CMD_EXIT);
      wait_n(n_req);
      chk(n_rst, n0 + 16'h2);
      chk(bexec, 1'b0);
      chk(isp_en, 1'b0);
    end
  endtask

  task t_user;
    reg [15:0] n0;
    begin
      // key left to lapse without a jump
      @(posedge clk) #1 key_wr = 1'b1;
      key_d = 8'h98;
      @(posedge clk) #1 key_wr = 1'b0;
      repeat (7) @(posedge clk);
      #1 chk(armed, 1'b1);
      @(posedge clk) #1 chk(armed, 1'b0);
      n0 = n_req;
      uadr = 16'h3003;
      uwd = 8'h6e;
      svc(8'h9c, `ENT_WRITE_BYTE);
      wait_n(n0);
      chk(n_req, n0);
      svc(8'h9a, `ENT_WRITE_BYTE);
      wait_n(n0 + 16'h1);
      chk(l_adr, 16'h3003);
      chk(l_wd, 8'h6e);
      chk(n_done, 16'h1);
      ucnt = 8'h03;
      svc(8'h98, `ENT_MULTI_READ);
      wait_n(n0 + 16'h4);
      chk(l_op, 3'h0);
      chk(l_adr, 16'h3005);
      acc = `MASS_CONFIRM;
      svc(8'h9b, `ENT_MASS_ERASE);
      wait_n(n0 + 16'h5);
      chk(l_op, 3'h3);
      chk(isp_en, 1'b1);
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    t_entry;
    t_cmds;
    t_user;
    test_done;
  end
endmodule
